// ---- inc/cs_regs.vh ----
// Register offsets, field positions and reset values for the channel-status bank
`ifndef CS_REGS_VH
`define CS_REGS_VH
`define ADDR_W 8
`define DATA_W 16
`define CS_BITS 40
`define CS_FRAMES 192
`define FRAME_CNT_W 8
`define OFF_OUTPUT_SETTINGS 8'h50
`define OFF_LEFT_UPPER 8'h51
`define OFF_LEFT_MIDDLE 8'h52
`define OFF_LEFT_LOWER 8'h53
`define OFF_RIGHT_UPPER 8'h54
`define OFF_RIGHT_MIDDLE 8'h55
`define OFF_RIGHT_LOWER 8'h56
`define RST_STATUS 16'h0000
`define RST_OUTPUT_SETTINGS 16'h0054
`define COPY_BIT 6
`define OUTPUT_SETTINGS_MASK 16'h015f
`define LOWER_MASK 16'h00fe
`define CONSUMER_BIT 0
`define FIELD_WORD_LEN_HI 35
`define FIELD_WORD_LEN_LO 33
`define FIELD_MAX_LEN 32
`define FIELD_CLK_ACC_HI 29
`define FIELD_CLK_ACC_LO 28
`define FIELD_FS_HI 27
`define FIELD_FS_LO 24
`define FIELD_CHAN_HI 23
`define FIELD_CHAN_LO 20
`define FIELD_SRC_HI 19
`define FIELD_SRC_LO 16
`define FIELD_CAT_HI 15
`define FIELD_CAT_LO 8
`define FIELD_MODE_HI 7
`define FIELD_MODE_LO 6
`define FIELD_EMPH_HI 5
`define FIELD_EMPH_LO 3
`define FIELD_COPYRIGHT 2
`define FIELD_NON_PCM 1
`endif

// ---- core/status_word_reg.v ----
// One 16-bit status register with write mask and reset value
`timescale 1ns/1ps
module status_word_reg #(
  parameter [15:0] WMASK = 16'hffff,
  parameter [15:0] RSTVAL = 16'h0000
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Write port
  input wire wr_en,
  input wire [15:0] wr_data,
  // Stored value
  output wire [15:0] value
);
  reg [15:0] word_ff;
  reg [15:0] nxt_word;

  always @* begin
    nxt_word = word_ff;
    if (wr_en) begin
      nxt_word = wr_data & WMASK;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      word_ff <= RSTVAL;
    end else begin
      word_ff <= nxt_word;
    end
  end

  assign value = word_ff;
endmodule // status_word_reg

// ---- core/cs_serializer.v ----
// Channel-status bit serializer for one subframe
`timescale 1ns/1ps
`include "cs_regs.vh"
module cs_serializer (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Frame timing
  input wire frame_strobe,
  input wire block_start,
  // Status word
  input wire [`CS_BITS-1:0] status_word,
  // Serial bit
  output wire status_bit
);
  reg [`FRAME_CNT_W-1:0] frame_ff;
  reg bit_ff;
  wire [`FRAME_CNT_W-1:0] slot;

  // Slot of the frame being strobed
  assign slot = block_start ? {`FRAME_CNT_W{1'b0}} : frame_ff;

  always @(posedge clk) begin
    if (rst) begin
      frame_ff <= {`FRAME_CNT_W{1'b0}};
      bit_ff <= 1'b0;
    end else if (frame_strobe) begin
      frame_ff <= slot + 8'h01;
      if (slot < `CS_BITS) begin
        bit_ff <= status_word[slot[5:0]];
      end else begin
        bit_ff <= 1'b0;
      end
    end
  end

  assign status_bit = bit_ff;
endmodule // cs_serializer

// ---- core/tx_channel_status.v ----
// Channel-status register bank of the serial audio transmitter
`timescale 1ns/1ps
`include "cs_regs.vh"
module tx_channel_status (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control port, decoded register access
  input wire wr_en,
  input wire rd_en,
  input wire [`ADDR_W-1:0] addr,
  input wire [`DATA_W-1:0] wr_data,
  output wire [`DATA_W-1:0] rd_data,
  output wire rd_hit,
  // Transmitter frame timing
  input wire frame_strobe,
  input wire block_start,
  // Status towards transmitter
  output wire [`CS_BITS-1:0] tx_status_bits_left,
  output wire [`CS_BITS-1:0] tx_status_bits_right,
  output wire status_bit_left,
  output wire status_bit_right,
  output wire copy_left_to_right
);
  wire [`DATA_W-1:0] l_up, l_mid, l_low, r_up, r_mid, r_low, settings;
  wire [`CS_BITS-1:0] left_word, right_word, right_tx;
  reg [`DATA_W-1:0] rd_data_ff;
  reg rd_hit_ff;
  reg [`DATA_W-1:0] nxt_rd_data;
  reg nxt_rd_hit;

  // Output settings register, only its copy bit is used here
  status_word_reg #(.WMASK(`OUTPUT_SETTINGS_MASK), .RSTVAL(`RST_OUTPUT_SETTINGS)) u_settings (
    .clk(clk), .rst(rst), .wr_en(wr_en && addr == `OFF_OUTPUT_SETTINGS), .wr_data(wr_data), .value(settings)
  );
  status_word_reg #(.WMASK(16'hffff), .RSTVAL(`RST_STATUS)) u_l_up (
    .clk(clk), .rst(rst), .wr_en(wr_en && addr == `OFF_LEFT_UPPER), .wr_data(wr_data), .value(l_up)
  );
  status_word_reg #(.WMASK(16'hffff), .RSTVAL(`RST_STATUS)) u_l_mid (
    .clk(clk), .rst(rst), .wr_en(wr_en && addr == `OFF_LEFT_MIDDLE), .wr_data(wr_data), .value(l_mid)
  );
  // Upper byte unused, consumer bit forced zero
  status_word_reg #(.WMASK(`LOWER_MASK), .RSTVAL(`RST_STATUS)) u_l_low (
    .clk(clk), .rst(rst), .wr_en(wr_en && addr == `OFF_LEFT_LOWER), .wr_data(wr_data), .value(l_low)
  );
  status_word_reg #(.WMASK(16'hffff), .RSTVAL(`RST_STATUS)) u_r_up (
    .clk(clk), .rst(rst), .wr_en(wr_en && addr == `OFF_RIGHT_UPPER), .wr_data(wr_data), .value(r_up)
  );
  status_word_reg #(.WMASK(16'hffff), .RSTVAL(`RST_STATUS)) u_r_mid (
    .clk(clk), .rst(rst), .wr_en(wr_en && addr == `OFF_RIGHT_MIDDLE), .wr_data(wr_data), .value(r_mid)
  );
  status_word_reg #(.WMASK(`LOWER_MASK), .RSTVAL(`RST_STATUS)) u_r_low (
    .clk(clk), .rst(rst), .wr_en(wr_en && addr == `OFF_RIGHT_LOWER), .wr_data(wr_data), .value(r_low)
  );

  // Stored fields pass through unchanged; right word is the left word while the copy bit is set
  assign left_word = {l_up, l_mid, l_low[7:0]};
  assign right_word = {r_up, r_mid, r_low[7:0]};
  assign copy_left_to_right = settings[`COPY_BIT];
  assign right_tx = copy_left_to_right ? left_word : right_word;
  assign tx_status_bits_left = left_word;
  assign tx_status_bits_right = right_tx;

  // Register read mux
  always @* begin
    nxt_rd_data = 16'h0000;
    nxt_rd_hit = 1'b0;
    if (rd_en) begin
      nxt_rd_hit = 1'b1;
      if (addr == `OFF_OUTPUT_SETTINGS) begin
        nxt_rd_data = settings;
      end else if (addr == `OFF_LEFT_UPPER) begin
        nxt_rd_data = l_up;
      end else if (addr == `OFF_LEFT_MIDDLE) begin
        nxt_rd_data = l_mid;
      end else if (addr == `OFF_LEFT_LOWER) begin
        nxt_rd_data = l_low;
      end else if (addr == `OFF_RIGHT_UPPER) begin
        nxt_rd_data = r_up;
      end else if (addr == `OFF_RIGHT_MIDDLE) begin
        nxt_rd_data = r_mid;
      end else if (addr == `OFF_RIGHT_LOWER) begin
        nxt_rd_data = r_low;
      end else begin
        nxt_rd_hit = 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      rd_data_ff <= 16'h0000;
      rd_hit_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_hit_ff <= nxt_rd_hit;
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_hit = rd_hit_ff;

  cs_serializer u_ser_left (
    .clk(clk), .rst(rst), .frame_strobe(frame_strobe), .block_start(block_start),
    .status_word(left_word), .status_bit(status_bit_left)
  );
  cs_serializer u_ser_right (
    .clk(clk), .rst(rst), .frame_strobe(frame_strobe), .block_start(block_start),
    .status_word(right_tx), .status_bit(status_bit_right)
  );
endmodule // tx_channel_status

// ---- verif/tx_channel_status_properties.sv ----
// Concurrent checks on the channel-status register bank
`timescale 1ns/1ps
`include "cs_regs.vh"
module tx_channel_status_properties (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control port
  input wire wr_en,
  input wire rd_en,
  input wire [`ADDR_W-1:0] addr,
  input wire [`DATA_W-1:0] wr_data,
  input wire [`DATA_W-1:0] rd_data,
  input wire rd_hit,
  // Status side
  input wire frame_strobe,
  input wire block_start,
  input wire [`CS_BITS-1:0] tx_status_bits_left,
  input wire [`CS_BITS-1:0] tx_status_bits_right,
  input wire status_bit_left,
  input wire copy_left_to_right
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_upper_write: assert property (wr_en && addr == 8'h51 |=> tx_status_bits_left[39:24] == $past(wr_data))
    else $error("upper write lost");
  chk_middle_write: assert property (wr_en && addr == 8'h52 |=> tx_status_bits_left[23:8] == $past(wr_data))
    else $error("middle write lost");
  chk_lower_write: assert property (wr_en && addr == 8'h53 |=> tx_status_bits_left[7:1] == $past(wr_data[7:1]))
    else $error("lower write lost");
  chk_consumer_zero: assert property (tx_status_bits_left[0] == 1'b0 && tx_status_bits_right[0] == 1'b0)
    else $error("consumer bit set");
  chk_mapped_hit: assert property (rd_en && addr >= 8'h50 && addr <= 8'h56 |=> rd_hit)
    else $error("mapped read missed");
  chk_unmapped_read: assert property (rd_en && addr > 8'h56 |=> !rd_hit && rd_data == 16'h0000)
    else $error("unmapped read answered");
  chk_copy_right: assert property (copy_left_to_right |-> tx_status_bits_right == tx_status_bits_left)
    else $error("right copy differs");
  chk_block_first: assert property (frame_strobe && block_start |=> status_bit_left == $past(tx_status_bits_left[0]))
    else $error("block start slot wrong");
endmodule // tx_channel_status_properties
bind tx_channel_status tx_channel_status_properties chk_u (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en),
  .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_hit(rd_hit), .frame_strobe(frame_strobe),
  .block_start(block_start), .tx_status_bits_left(tx_status_bits_left),
  .tx_status_bits_right(tx_status_bits_right), .status_bit_left(status_bit_left),
  .copy_left_to_right(copy_left_to_right));

// ---- verif/ctrl_host.sv ----
// Control-port host issuing register writes and reads
`timescale 1ns/1ps
module ctrl_host (
  // Clock
  input wire clk,
  // Register access
  output logic wr_en = 1'b0,
  output logic rd_en = 1'b0,
  output logic [7:0] addr = 8'h00,
  output logic [15:0] wr_data = 16'h0000,
  input wire [15:0] rd_data,
  input wire rd_hit
);
  // Each access starts just after an edge, so a strobe never drops and rises in one step
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(posedge clk);
    #1 wr_en = 1'b0;
  endtask
  // Answer lands one cycle after the strobe
  task rd(input logic [7:0] a, output logic [15:0] d, output logic h);
    @(posedge clk);
    #1;
    addr = a;
    rd_en = 1'b1;
    @(posedge clk);
    #1 rd_en = 1'b0;
    d = rd_data;
    h = rd_hit;
  endtask
endmodule // ctrl_host

// ---- verif/tx_channel_status_test.sv ----
// Self-checking bench for the channel-status register bank
`timescale 1ns/1ps
`include "cs_regs.vh"
module tx_channel_status_test;
  logic clk = 1'b0, rst = 1'b1, frame_strobe = 1'b0, block_start = 1'b0, hit;
  logic wr_en, rd_en, rd_hit, status_bit_left, status_bit_right, copy_left_to_right;
  logic [7:0] addr;
  logic [15:0] wr_data, rd_data, got;
  logic [39:0] tx_left, tx_right;
  logic [39:0] left_bits = 40'hffffa5c3fe, right_bits = 40'h1234567804;
  int n_errors = 0, checks_done = 0;
  // Rows: offset, write data, read-back, mapped; 0005 sets the refused bit 0
  logic [40:0] rows [8] = '{{8'h50, 16'h0000, 16'h0000, 1'b1}, {8'h51, 16'hffff, 16'hffff, 1'b1},
    {8'h52, 16'ha5c3, 16'ha5c3, 1'b1}, {8'h53, 16'hffff, 16'h00fe, 1'b1}, {8'h54, 16'h1234, 16'h1234, 1'b1},
    {8'h55, 16'h5678, 16'h5678, 1'b1}, {8'h56, 16'h0005, 16'h0004, 1'b1}, {8'h4f, 16'hffff, 16'h0000, 1'b0}};
  always #2 clk = ~clk;
  ctrl_host host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .rd_data(rd_data), .rd_hit(rd_hit));
  tx_channel_status dut_u (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .rd_data(rd_data), .rd_hit(rd_hit), .frame_strobe(frame_strobe), .block_start(block_start),
    .tx_status_bits_left(tx_left), .tx_status_bits_right(tx_right), .status_bit_left(status_bit_left),
    .status_bit_right(status_bit_right), .copy_left_to_right(copy_left_to_right));
  task chk(input logic [39:0] g, input logic [39:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    results;
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 8'h50; i < 8'h57; i++) begin
      host_u.rd(i[7:0], got, hit);
      chk(got, i == 8'h50 ? `RST_OUTPUT_SETTINGS : `RST_STATUS);
      chk(hit, 1'b1);
    end
    chk(copy_left_to_right, 1'b1);
    foreach (rows[r]) begin
      host_u.wr(rows[r][40:33], rows[r][32:17]);
      host_u.rd(rows[r][40:33], got, hit);
      chk(got, rows[r][16:1]);
      chk(hit, rows[r][0]);
    end
    chk(tx_left, left_bits);
    chk(tx_right, right_bits);
    // Strobe held high across the frames, one frame per cycle
    frame_strobe = 1'b1;
    for (int n = 0; n < 42; n++) begin
      block_start = (n == 0);
      @(posedge clk);
      #1;
      chk(status_bit_left, n < 40 ? left_bits[n] : 1'b0);
      chk(status_bit_right, n < 40 ? right_bits[n] : 1'b0);
    end
    frame_strobe = 1'b0;
    block_start = 1'b0;
    host_u.wr(8'h50, 16'h0040);
    chk(tx_right, left_bits);
    results;
  end
endmodule // tx_channel_status_test
